// ### core/expander_defines.svh
// constant values shared by the input expander design
`ifndef EXPANDER_DEFINES_SVH
`define EXPANDER_DEFINES_SVH

// ---------------------------------------------------------------
// clock and alert timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define ALERT_VALID_MAX_NS 4000
`define ALERT_VALID_CYC    (`ALERT_VALID_MAX_NS / `CLK_PERIOD_NS)
`define ALERT_CLEAR_MAX_NS 4000
`define ALERT_CLEAR_CYC    (`ALERT_CLEAR_MAX_NS / `CLK_PERIOD_NS)

// ---------------------------------------------------------------
// slave address and field layout
// ---------------------------------------------------------------
`define SLAVE_ADDR_BASE    7'h60
`define SLAVE_ADDR_LOW_POS 0
`define SLAVE_ADDR_HIGH_POS 2
`define BYTE_BITS          4'h8
`define MASK_RESET         8'hFF

// ---------------------------------------------------------------
// address pin levels
// ---------------------------------------------------------------
`define PIN_LVL_GND        2'h0
`define PIN_LVL_SUPPLY     2'h1
`define PIN_LVL_SCL        2'h2
`define PIN_LVL_SDA        2'h3

// ---------------------------------------------------------------
// synchronised pin vector layout
// ---------------------------------------------------------------
`define SYNC_W             13
`define SYNC_SCL           0
`define SYNC_SDA           1
`define SYNC_CLR           2
`define SYNC_ADDR_LO       3
`define SYNC_ADDR_HI       4
`define SYNC_LINES         5
`define SYNC_SETTLE_CYC    3'h4

`endif

// ### core/expander_pkg.sv
// types shared by the input expander design
package expander_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [1:0] pin_lvl_t;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_ACK_A = 7'h04,
		ST_WRITE = 7'h08,
		ST_ACK_W = 7'h10,
		ST_READ  = 7'h20,
		ST_MACK  = 7'h40
	} bus_state_e;

endpackage

// ### core/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d_in,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;

	// rst_val is only taken after release, never as an async load
	logic         init_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff   <= '0;
			s2_ff   <= '0;
			s3_ff   <= '0;
			q_ff    <= '0;
			init_ff <= 1'b0;
		end else begin
			s1_ff   <= d_in;
			init_ff <= 1'b1;
			// later stages start at the idle value so no reset zero leaks out
			if (!init_ff) begin
				s2_ff <= rst_val;
				s3_ff <= rst_val;
				q_ff  <= rst_val;
			end else begin
				s2_ff <= s1_ff;
				s3_ff <= s2_ff;
				q_ff  <= (s2_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
			end
		end
	end

	assign q_out = q_ff;

endmodule

`default_nettype wire

// ### core/input_expander_change_alert.sv
// eight-line input expander with change alert on a two-wire bus
// Summary of operation
// - latch every change on all eight lines
// - per-line mask gates changes onto alert
// - any acknowledged access to this device clears pending alert
// - clear pin aborts the serial transfer
// - two four-level pins give 16 addresses
// - address switches pullups per four-line group
// - alert valid within 4 us of change
// - alert released within 4 us of ack
// - addresses span 0x60 to 0x6F
`timescale 1ns/100ps
`default_nettype none
`include "expander_defines.svh"

module input_expander_change_alert (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	input  wire logic                 bus_clear_n,
	input  wire logic                 addr_sel_low_pin,
	input  wire logic                 addr_sel_high_pin,
	input  wire expander_pkg::byte_t  input_lines,
	output logic                      alert_out,
	output logic                      alert_oe,
	output logic [1:0]                pullup_en
);
	import expander_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [`SYNC_W-1:0] raw_pins;
	logic [`SYNC_W-1:0] idle_pins;
	logic [`SYNC_W-1:0] sync_pins;

	assign raw_pins  = {input_lines, addr_sel_high_pin, addr_sel_low_pin, bus_clear_n, sda_in, scl_in};
	// bus lines and clear start as released, inputs start as low
	assign idle_pins = {8'h00, 2'h0, 3'h7};

	pin_sync3 #(
		.W(`SYNC_W)
	) u_sync (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.d_in    (raw_pins),
		.rst_val (idle_pins),
		.q_out   (sync_pins)
	);

	wire logic       scl_s   = sync_pins[`SYNC_SCL];
	wire logic       sda_s   = sync_pins[`SYNC_SDA];
	wire logic       clr_s   = sync_pins[`SYNC_CLR];
	wire logic [1:0] apin_s  = sync_pins[`SYNC_ADDR_HI:`SYNC_ADDR_LO];
	wire byte_t      lines_s = sync_pins[`SYNC_LINES +: 8];

	// ---------------------------------------------------------------
	// bus edge and condition detect
	// ---------------------------------------------------------------
	logic       scl_d_ff;
	logic       sda_d_ff;
	// pin history before the synchroniser holds real levels would misclassify the pins
	logic [2:0] settle_ff;
	wire logic  apin_ok = (settle_ff == `SYNC_SETTLE_CYC);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_ff  <= 1'b1;
			sda_d_ff  <= 1'b1;
			settle_ff <= 3'h0;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
			if (!apin_ok)
				settle_ff <= settle_ff + 3'h1;
		end
	end

	wire logic scl_rise  = scl_s & ~scl_d_ff;
	wire logic scl_fall  = ~scl_s & scl_d_ff;
	wire logic bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire logic bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	// ---------------------------------------------------------------
	// four-level address pin decode
	// ---------------------------------------------------------------
	logic [1:0] seen_lo_ff;
	logic [1:0] seen_hi_ff;
	logic [1:0] diff_scl_ff;

	// a pin tied to scl never disagrees with it; one tied to sda does at start
	function automatic pin_lvl_t pin_level(input logic lo, input logic hi, input logic dscl);
		if (!lo)
			pin_level = `PIN_LVL_SUPPLY;
		else if (!hi)
			pin_level = `PIN_LVL_GND;
		else if (!dscl)
			pin_level = `PIN_LVL_SCL;
		else
			pin_level = `PIN_LVL_SDA;
	endfunction

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_apin
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					seen_lo_ff[gp]  <= 1'b0;
					seen_hi_ff[gp]  <= 1'b0;
					diff_scl_ff[gp] <= 1'b0;
				end else if (apin_ok) begin
					seen_lo_ff[gp]  <= seen_lo_ff[gp] | ~apin_s[gp];
					seen_hi_ff[gp]  <= seen_hi_ff[gp] | apin_s[gp];
					diff_scl_ff[gp] <= diff_scl_ff[gp] | (apin_s[gp] ^ scl_s);
				end
			end
		end
	endgenerate

	wire pin_lvl_t   lvl_low  = pin_level(seen_lo_ff[0], seen_hi_ff[0], diff_scl_ff[0]);
	wire pin_lvl_t   lvl_high = pin_level(seen_lo_ff[1], seen_hi_ff[1], diff_scl_ff[1]);
	wire logic [6:0] own_addr = `SLAVE_ADDR_BASE | {3'h0, lvl_high, lvl_low};

	// ---------------------------------------------------------------
	// serial slave
	// ---------------------------------------------------------------
	bus_state_e state_ff;
	bus_state_e nxt_state;
	logic [3:0] bit_cnt_ff;
	logic [3:0] nxt_bit_cnt;
	byte_t      shift_ff;
	byte_t      nxt_shift;
	byte_t      tx_ff;
	byte_t      nxt_tx;
	byte_t      mask_ff;
	byte_t      nxt_mask;
	logic       rw_ff;
	logic       nxt_rw;
	logic       mack_ff;
	logic       nxt_mack;
	logic       sda_oe_ff;
	logic       nxt_sda_oe;
	logic       access_ack;

	wire logic addr_hit  = (shift_ff[7:1] == own_addr);
	wire logic byte_done = (bit_cnt_ff == `BYTE_BITS);

	always_comb begin
		nxt_state   = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift   = shift_ff;
		nxt_tx      = tx_ff;
		nxt_mask    = mask_ff;
		nxt_rw      = rw_ff;
		nxt_mack    = mack_ff;
		nxt_sda_oe  = sda_oe_ff;
		access_ack  = 1'b0;
		if (scl_rise && state_ff != ST_IDLE) begin
			nxt_shift   = {shift_ff[6:0], sda_s};
			nxt_bit_cnt = bit_cnt_ff + 4'h1;
			nxt_mack    = ~sda_s;
		end
		case (state_ff)
			ST_ADDR: begin
				if (scl_fall && byte_done) begin
					if (addr_hit) begin
						nxt_state  = ST_ACK_A;
						nxt_rw     = shift_ff[0];
						nxt_sda_oe = 1'b1;
						access_ack = 1'b1;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_ACK_A, ST_ACK_W: begin
				if (scl_fall) begin
					nxt_bit_cnt = 4'h0;
					if (rw_ff) begin
						nxt_tx     = lines_s;
						nxt_sda_oe = ~lines_s[7];
						nxt_state  = ST_READ;
					end else begin
						nxt_sda_oe = 1'b0;
						nxt_state  = ST_WRITE;
					end
				end
			end
			ST_WRITE: begin
				if (scl_fall && byte_done) begin
					nxt_mask   = shift_ff;
					nxt_sda_oe = 1'b1;
					nxt_state  = ST_ACK_W;
				end
			end
			ST_READ: begin
				if (scl_fall) begin
					if (byte_done) begin
						nxt_sda_oe = 1'b0;
						nxt_state  = ST_MACK;
					end else begin
						nxt_tx     = {tx_ff[6:0], 1'b0};
						nxt_sda_oe = ~tx_ff[6];
					end
				end
			end
			ST_MACK: begin
				if (scl_fall) begin
					nxt_bit_cnt = 4'h0;
					if (mack_ff) begin
						nxt_tx     = lines_s;
						nxt_sda_oe = ~lines_s[7];
						nxt_state  = ST_READ;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			default: begin
				nxt_state  = ST_IDLE;
				nxt_sda_oe = 1'b0;
			end
		endcase
		if (bus_start) begin
			nxt_state   = ST_ADDR;
			nxt_bit_cnt = 4'h0;
			nxt_sda_oe  = 1'b0;
		end
		if (bus_stop || !clr_s) begin
			nxt_state  = ST_IDLE;
			nxt_sda_oe = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff   <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff   <= 8'h00;
			tx_ff      <= 8'h00;
			mask_ff    <= `MASK_RESET;
			rw_ff      <= 1'b0;
			mack_ff    <= 1'b0;
			sda_oe_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff   <= nxt_shift;
			tx_ff      <= nxt_tx;
			mask_ff    <= nxt_mask;
			rw_ff      <= nxt_rw;
			mack_ff    <= nxt_mack;
			sda_oe_ff  <= nxt_sda_oe;
		end
	end

	// ---------------------------------------------------------------
	// change latch and alert
	// ---------------------------------------------------------------
	byte_t prev_ff;
	byte_t change_ff;
	byte_t nxt_change;
	logic  alert_oe_ff;
	logic  [1:0] pullup_ff;

	// a change in the clearing cycle survives: set wins over clear
	assign nxt_change = (access_ack ? 8'h00 : change_ff) | (lines_s ^ prev_ff);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff     <= 8'h00;
			change_ff   <= 8'h00;
			alert_oe_ff <= 1'b0;
			pullup_ff   <= 2'h0;
		end else begin
			prev_ff     <= lines_s;
			change_ff   <= nxt_change;
			alert_oe_ff <= |(nxt_change & mask_ff);
			pullup_ff   <= {lvl_high[0], lvl_low[0]};
		end
	end

	assign alert_oe  = alert_oe_ff;
	assign alert_out = 1'b0 & alert_oe_ff;
	assign sda_oe    = sda_oe_ff;
	assign sda_out   = 1'b0 & sda_oe_ff;
	assign pullup_en = pullup_ff;

endmodule

`default_nettype wire

// ### tb/expander_sva.sv
// port-level assertions for the input expander change alert
`timescale 1ns/100ps
`default_nettype none
module expander_sva (
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire logic                scl_in,
	input wire logic                sda_in,
	input wire logic                sda_out,
	input wire logic                sda_oe,
	input wire logic                bus_clear_n,
	input wire logic                addr_sel_low_pin,
	input wire logic                addr_sel_high_pin,
	input wire expander_pkg::byte_t input_lines,
	input wire logic                alert_out,
	input wire logic                alert_oe,
	input wire logic [1:0]          pullup_en
);
	import expander_pkg::*;
	// ------------------
	// change age counter
	// ------------------
	byte_t      seen_ff;
	logic [3:0] since_ff;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			seen_ff  <= 8'h00;
			since_ff <= 4'h0;
		end else begin
			seen_ff  <= input_lines;
			since_ff <= (input_lines != seen_ff) ? 4'h0 : (since_ff == 4'hF) ? since_ff : since_ff + 4'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_sda_val; sda_out == 1'b0; endproperty
	a_sda_val: assert property (p_sda_val) else $error("sda drive value high");
	property p_alert_val; alert_out == 1'b0; endproperty
	a_alert_val: assert property (p_alert_val) else $error("alert drive value high");
	// a few sync stages only, so anything older means a phantom alert
	property p_alert_src; $rose(alert_oe) |-> since_ff < 4'hC; endproperty
	a_alert_src: assert property (p_alert_src) else $error("alert without recent change");
	property p_alert_fall; $fell(alert_oe) |-> sda_oe; endproperty
	a_alert_fall: assert property (p_alert_fall) else $error("alert dropped outside ack");
	property p_alert_hold; alert_oe && !sda_oe |=> alert_oe || sda_oe; endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("pending alert lost");
	property p_clr; !bus_clear_n [*8] |-> !sda_oe; endproperty
	a_clr: assert property (p_clr) else $error("sda driven during clear");
	// releasing sda while scl is high would fake a stop
	property p_sda_edge; $fell(sda_oe) && bus_clear_n |-> !scl_in; endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("sda released with scl high");
	property p_ack_hold; $rose(sda_oe) && bus_clear_n |=> sda_oe [*8]; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("sda drive too short");
	property p_oe_rise; $rose(sda_oe) |-> !scl_in && $past(scl_in, 8); endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("sda drive not after scl fall");
endmodule
bind input_expander_change_alert expander_sva expander_sva_i (.mclk(mclk), .rst_n(rst_n), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .bus_clear_n(bus_clear_n),
	.addr_sel_low_pin(addr_sel_low_pin), .addr_sel_high_pin(addr_sel_high_pin), .input_lines(input_lines),
	.alert_out(alert_out), .alert_oe(alert_oe), .pullup_en(pullup_en));
`default_nettype wire

// ### tb/bus_master_model.sv
// two-wire bus master model for the expander's serial pins
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
	input  wire logic mclk,
	input  wire logic sda_line,
	output logic      scl_drv,
	output logic      sda_low
);
	initial begin
		scl_drv = 1'b1;
		sda_low = 1'b0;
	end
	// ---------------
	// bus conditions
	// ---------------
	task automatic gap(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic start_cond();
		sda_low = 1'b1;
		gap(80);
		scl_drv = 1'b0;
		gap(70);
	endtask
	// long tail keeps the bus free time before the next start
	task automatic stop_cond();
		sda_low = 1'b1;
		gap(70);
		scl_drv = 1'b1;
		gap(80);
		sda_low = 1'b0;
		gap(140);
	endtask
	task automatic bit_slot(input logic v, output logic s);
		sda_low = !v;
		gap(70);
		scl_drv = 1'b1;
		gap(40);
		s = sda_line;
		gap(40);
		scl_drv = 1'b0;
		gap(70);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic rd, input logic nack, output logic [7:0] rx,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(tx[i] | rd, s);
			rx[i] = s;
		end
		bit_slot(rd ? nack : 1'b1, s);
		ack = !s;
	endtask
endmodule
`default_nettype wire

// ### tb/input_expander_change_alert_tb.sv
// self-checking bench for the input expander change alert
`timescale 1ns/100ps
`default_nettype none
module input_expander_change_alert_tb;
	import expander_pkg::*;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic       clr_n = 1'b1;
	byte_t      lines = 8'h00;
	pin_lvl_t   lo_lvl = 2'h1;
	pin_lvl_t   hi_lvl = 2'h2;
	wire logic  scl, sda_low, sda_oe, sda_out, alert_oe, alert_out, lo_pin, hi_pin;
	wire logic [1:0] pull;
	wire logic  sda = !(sda_low || (sda_oe && !sda_out));
	int         fails = 0;
	int         comparisons = 0;
	int         cyc = 0;
	function automatic logic tie(pin_lvl_t l, logic c, logic d);
		return l[1] ? (l[0] ? d : c) : l[0];
	endfunction
	assign lo_pin = tie(lo_lvl, scl, sda);
	assign hi_pin = tie(hi_lvl, scl, sda);
	always #5 mclk = ~mclk;
	input_expander_change_alert input_expander_change_alert_i (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .bus_clear_n(clr_n), .addr_sel_low_pin(lo_pin),
		.addr_sel_high_pin(hi_pin), .input_lines(lines), .alert_out(alert_out), .alert_oe(alert_oe),
		.pullup_en(pull));
	bus_master_model bus_master_model_i (.mclk(mclk), .sda_line(sda), .scl_drv(scl), .sda_low(sda_low));
	// ---------------
	// helpers
	// ---------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// 400 cycles is the 4 us alert bound
	task automatic wait_alert(input logic lvl);
		// step past the edge so the freshly launched output is settled
		for (int n = 0; n < 400 && alert_oe !== lvl; n++) begin
			@(posedge mclk);
			#1;
		end
	endtask
	task automatic xact(input logic [6:0] a, input logic rd, input byte_t wd, output byte_t rx,
		output logic [1:0] ak);
		logic [7:0] junk;
		rx = 8'h00;
		ak = 2'b00;
		bus_master_model_i.start_cond();
		bus_master_model_i.xfer({a, rd}, 1'b0, 1'b0, junk, ak[1]);
		if (ak[1])
			bus_master_model_i.xfer(wd, rd, 1'b1, rx, ak[0]);
		bus_master_model_i.stop_cond();
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		logic [6:0] own;
		byte_t      m, rx;
		logic [1:0] ak;
		void'($urandom(32'h7b23));
		for (int c = 0; c < 2; c++) begin
			rst_n = 1'b0;
			lo_lvl = c ? 2'h0 : 2'h1;
			hi_lvl = c ? 2'h3 : 2'h2;
			lines = 8'($urandom);
			repeat (5) @(posedge mclk);
			#1 rst_n = 1'b1;
			own = 7'h60 | {3'h0, hi_lvl, lo_lvl};
			repeat (20) @(posedge mclk);
			#1;
			xact(own ^ 7'h10, 1'b0, 8'h00, rx, ak);
			chk("far address ack", 8'h00, {6'h00, ak});
			xact(own ^ 7'h01, 1'b0, 8'h00, rx, ak);
			chk("near address ack", 8'h00, {6'h00, ak});
			chk("pullups", {6'h00, hi_lvl[0], lo_lvl[0]}, {6'h00, pull});
			m = 8'($urandom);
			m[0] = 1'b1;
			m[7] = 1'b0;
			xact(own, 1'b0, m, rx, ak);
			chk("write acks", 8'h03, {6'h00, ak});
			chk("alert after write", 8'h00, {7'h00, alert_oe});
			lines[7] = ~lines[7];
			wait_alert(1'b1);
			chk("alert masked line", 8'h00, {7'h00, alert_oe});
			lines[0] = ~lines[0];
			wait_alert(1'b1);
			lines[0] = ~lines[0];
			chk("alert chosen line", 8'h01, {7'h00, alert_oe});
			chk("alert pin level", 8'h00, {7'h00, alert_out});
			repeat (20) @(posedge mclk);
			#1;
			chk("alert kept", 8'h01, {7'h00, alert_oe});
			xact(own, 1'b1, 8'h00, rx, ak);
			chk("read ack", 8'h02, {6'h00, ak});
			chk("read byte", lines, rx);
			wait_alert(1'b0);
			chk("alert after read", 8'h00, {7'h00, alert_oe});
			fork
				xact(own, 1'b0, 8'hA5, rx, ak);
				begin
					repeat (600) @(posedge mclk);
					#1 clr_n = 1'b0;
					repeat (60) @(posedge mclk);
					#1 clr_n = 1'b1;
				end
			join
			chk("ack after clear", 8'h00, {6'h00, ak});
		end
		end_of_test();
	end
endmodule
`default_nettype wire
